// ===== design/input_sync.sv
// Three-stage synchroniser with agreement filter for a pin level.
// Assumes the input is asynchronous to pclk.
module input_sync
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);

    logic [2:0] sh_q;

    // Shift chain; only stages 2 and 3 are compared
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sh_q <= 3'h0;
        else
            sh_q <= {sh_q[1:0], din};
    end

    // Output follows once the last two stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dout <= 1'b0;
        else if (sh_q[1] == sh_q[2])
            dout <= sh_q[2];
    end

endmodule // input_sync

// ===== design/rdc_obs_pkg.sv
// Package: register map, field layouts, reset values and timing constants
// of the resolver velocity, peak sample and debug select block.
// Assumes a 32-bit APB slave at pclk of 20 MHz.
package rdc_obs_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] velocity_off   = 8'h5c;
    localparam logic [7:0] peak_off       = 8'h60;
    localparam logic [7:0] debug_off      = 8'h64;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int sine_pk_lsb    = 16;
    localparam int sine_pk_msb    = 28;
    localparam int cos_pk_lsb     = 0;
    localparam int cos_pk_msb     = 12;
    localparam int period_sel_lsb = 28;
    localparam int period_sel_msb = 29;
    localparam int data_sel_lsb   = 16;
    localparam int data_sel_msb   = 22;
    localparam int velocity_sign_lsb = 25;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] velocity_rst   = 32'h0000_0000;
    localparam logic [31:0] peak_rst       = 32'h0000_0000;
    localparam logic [1:0]  period_sel_rst = 2'h0;
    localparam logic [6:0]  data_sel_rst   = 7'h00;

    // ------------------------------------------------------------------
    // Debug selector codes
    // ------------------------------------------------------------------
    localparam logic [6:0] sel_sar_adc    = 7'h3b;
    localparam logic [6:0] sel_loop_ctl   = 7'h2f;
    localparam logic [6:0] sel_sq_integ   = 7'h2e;
    localparam logic [6:0] sel_sq_sum     = 7'h2d;
    localparam logic [6:0] sel_cos_offset = 7'h1d;
    localparam logic [6:0] sel_sin_offset = 7'h1c;
    localparam logic [6:0] sel_cos_sample = 7'h1a;
    localparam logic [6:0] sel_sin_sample = 7'h19;

    // ------------------------------------------------------------------
    // Measuring windows, in ns, and their cycle counts at pclk
    // ------------------------------------------------------------------
    localparam int clk_period_ns = 50;
    localparam int win0_ns       = 12800;
    localparam int win1_ns       = 51200;
    localparam int win2_ns       = 102400;
    localparam int win3_ns       = 204800;
    localparam logic [12:0] win0_cyc = 13'((win0_ns + clk_period_ns - 1) / clk_period_ns);
    localparam logic [12:0] win1_cyc = 13'((win1_ns + clk_period_ns - 1) / clk_period_ns);
    localparam logic [12:0] win2_cyc = 13'((win2_ns + clk_period_ns - 1) / clk_period_ns);
    localparam logic [12:0] win3_cyc = 13'((win3_ns + clk_period_ns - 1) / clk_period_ns);

    // Internal converter quantities routed to the debug port
    typedef struct packed {
        logic [11:0] sar_adc;
        logic [7:0]  loop_ctl;
        logic [15:0] sq_integ;
        logic [15:0] sq_sum;
        logic [9:0]  cos_offset;
        logic [9:0]  sin_offset;
        logic [12:0] cos_sample;
        logic [12:0] sin_sample;
    } debug_src_t;

endpackage

// ===== design/rdc_observe.sv
// Read-side observation block: velocity, excitation-peak samples and a
// debug select port, on an APB slave.
// Assumes converter quantities arrive on pclk; the peak trigger is a pin.
//
// Local design decision: register access over APB.

// Behaviour
// - Velocity is angle change, 32-bit two's complement
// - LSB 0.07 rpm, bit 24 1171875 rpm
// - Angle-error lock forces velocity to zero
// - Two-bit selector picks measuring window length
// - Peak trigger captures sine into bits 28:16
// - Peak trigger captures cosine into bits 12:0
// - Samples are two's complement relative to common
// - Reserved bits read as reset value
// - Velocity and peak registers read-only, any width
// - Debug register read/write; data field read-only
// - Seven-bit selector routes internal quantity to data
// - Codes 3b, 2f give ADC and loop control
// - Codes 2e, 2d give sum-of-squares values
// - Codes 1d, 1c give common-mode offsets
// - Codes 1a, 19 give converter sine/cosine samples
module rdc_observe
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Converter side
    input  wire logic [15:0]             angle_value,
    input  wire logic                    angle_error_lock,
    input  wire logic                    excitation_peak_trig,
    input  wire logic [12:0]             sine_monitor_input,
    input  wire logic [12:0]             cosine_monitor_input,
    input  wire rdc_obs_pkg::debug_src_t debug_src,
    output logic      [1:0]              velocity_period_sel
);

    // ------------------------------------------------------------------
    // Local signals
    // ------------------------------------------------------------------
    logic [31:0] velocity_value;
    logic [12:0] sine_peak_sample_q;
    logic [12:0] cosine_peak_sample_q;
    logic [1:0]  period_sel_q;
    logic [6:0]  debug_data_select_q;
    logic [15:0] debug_data;
    logic        trig_s;
    logic        trig_prev_q;
    logic        trig_rise;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;

    // ------------------------------------------------------------------
    // Velocity measurement
    // ------------------------------------------------------------------
    velocity_meter u_velocity_meter
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .angle      (angle_value),
        .period_sel (period_sel_q),
        .lock       (angle_error_lock),
        .velocity   (velocity_value)
    );

    assign velocity_period_sel = period_sel_q;

    // ------------------------------------------------------------------
    // Excitation peak capture
    // ------------------------------------------------------------------
    // Trigger comes from the excitation timer as a pin; filter it first
    input_sync u_trig_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (excitation_peak_trig),
        .dout    (trig_s)
    );

    // Rising edge of the filtered trigger, one capture per peak
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_prev_q <= 1'b0;
        else
            trig_prev_q <= trig_s;
    end

    assign trig_rise = trig_s & ~trig_prev_q;

    // Monitor inputs are already signed offsets from common; stored as is
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sine_peak_sample_q   <= 13'h0;
            cosine_peak_sample_q <= 13'h0;
        end
        else if (trig_rise)
        begin
            sine_peak_sample_q   <= sine_monitor_input;
            cosine_peak_sample_q <= cosine_monitor_input;
        end
    end

    // ------------------------------------------------------------------
    // Debug data routing
    // ------------------------------------------------------------------
    // Unlisted codes read zero rather than leaving stale data
    always_comb
    begin
        case (debug_data_select_q)
            rdc_obs_pkg::sel_sar_adc:
                debug_data = {4'h0, debug_src.sar_adc};
            rdc_obs_pkg::sel_loop_ctl:
                debug_data = {8'h0, debug_src.loop_ctl};
            rdc_obs_pkg::sel_sq_integ:
                debug_data = debug_src.sq_integ;
            rdc_obs_pkg::sel_sq_sum:
                debug_data = debug_src.sq_sum;
            rdc_obs_pkg::sel_cos_offset:
                debug_data = {6'h0, debug_src.cos_offset};
            rdc_obs_pkg::sel_sin_offset:
                debug_data = {6'h0, debug_src.sin_offset};
            rdc_obs_pkg::sel_cos_sample:
                debug_data = {3'h0, debug_src.cos_sample};
            rdc_obs_pkg::sel_sin_sample:
                debug_data = {3'h0, debug_src.sin_sample};
            default:
                debug_data = 16'h0;
        endcase
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign addr_ok = (paddr == rdc_obs_pkg::velocity_off)
                   | (paddr == rdc_obs_pkg::peak_off)
                   | (paddr == rdc_obs_pkg::debug_off);
    // Writes to read-only registers are ignored silently, not errored
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = psel & penable & pwrite & addr_ok;
    assign rd_en   = psel & ~penable & ~pwrite;

    // Control fields of the debug register; byte lanes 2 and 3 only.
    // Reserved bits are not stored, so a stray write cannot stick.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            period_sel_q        <= rdc_obs_pkg::period_sel_rst;
            debug_data_select_q <= rdc_obs_pkg::data_sel_rst;
        end
        else if (wr_en && paddr == rdc_obs_pkg::debug_off)
        begin
            if (pstrb[3])
                period_sel_q <= pwdata[rdc_obs_pkg::period_sel_msb:
                                       rdc_obs_pkg::period_sel_lsb];
            if (pstrb[2])
                debug_data_select_q <= pwdata[rdc_obs_pkg::data_sel_msb:
                                              rdc_obs_pkg::data_sel_lsb];
        end
    end

    // Read data registered in setup so it stands through the access
    // phase; sub-word reads just use the wanted lanes of this word.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (rd_en)
        begin
            case (paddr)
                rdc_obs_pkg::velocity_off:
                    prdata <= velocity_value;
                rdc_obs_pkg::peak_off:
                    prdata <= {3'h0, sine_peak_sample_q,
                               3'h0, cosine_peak_sample_q};
                rdc_obs_pkg::debug_off:
                    prdata <= {2'h0, period_sel_q, 5'h0,
                               debug_data_select_q, debug_data};
                default:
                    prdata <= 32'h0;
            endcase
        end
    end

endmodule // rdc_observe

// ===== design/velocity_meter.sv
// Velocity meter: angle difference over a selectable measuring window.
// Assumes the angle input is a 16-bit value on pclk, wrapping naturally.
module velocity_meter
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] angle,
    input  wire logic [1:0]  period_sel,
    input  wire logic        lock,
    output logic      [31:0] velocity
);

    logic [12:0] cnt_q;
    logic [12:0] limit;
    logic [15:0] start_q;
    logic [15:0] delta;
    logic        win_end;

    // Window length from the selector
    always_comb
    begin
        case (period_sel)
            2'h0:    limit = rdc_obs_pkg::win0_cyc;
            2'h1:    limit = rdc_obs_pkg::win1_cyc;
            2'h2:    limit = rdc_obs_pkg::win2_cyc;
            2'h3:    limit = rdc_obs_pkg::win3_cyc;
            default: limit = rdc_obs_pkg::win0_cyc;
        endcase
    end

    assign win_end = (cnt_q >= limit - 13'h1);
    // Wrapping difference gives the signed shortest angle step
    assign delta   = angle - start_q;

    // Window counter; a selector change takes effect at once via >=
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 13'h0;
        else if (win_end)
            cnt_q <= 13'h0;
        else
            cnt_q <= cnt_q + 13'h1;
    end

    // Angle snapshot at window start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_q <= 16'h0;
        else if (win_end)
            start_q <= angle;
    end

    // Result refreshed once per window, zero while locked.
    // Angle LSB spans 2^9 velocity LSBs; sign extends through bit 31.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            velocity <= rdc_obs_pkg::velocity_rst;
        else if (lock)
            velocity <= 32'h0;
        else if (win_end)
            velocity <= {{7{delta[15]}}, delta, 9'h0};
    end

endmodule // velocity_meter

// ===== tb/rdc_observe_sva.sv
// Checker for rdc_observe: bus answer, reserved bits, lock, period select.
// Assumes it is bound to rdc_observe and sees only its ports.
module rdc_observe_sva
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [7:0]              paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic [15:0]             angle_value,
    input wire logic                    angle_error_lock,
    input wire logic                    excitation_peak_trig,
    input wire logic [12:0]             sine_monitor_input,
    input wire logic [12:0]             cosine_monitor_input,
    input wire rdc_obs_pkg::debug_src_t debug_src,
    input wire logic [1:0]              velocity_period_sel
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----
    // Helpers
    // ----
    logic wr_sel;
    logic mapped;
    assign wr_sel = psel && penable && pwrite && paddr == 8'h64 && pstrb[3];
    assign mapped = paddr inside {8'h5c, 8'h60, 8'h64};
    sequence s_rd(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    // ----
    // Assertions
    // ----
    a_ready_const: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong");
    a_lock_zero: assert property ((angle_error_lock && $past(angle_error_lock))
        ##0 s_rd(8'h5c) |=> prdata == 32'h0000_0000) else $error("velocity not 0 under lock");
    a_vel_sign: assert property (s_rd(8'h5c) |=> prdata[31:24] == {8{prdata[24]}})
        else $error("velocity sign bits differ");
    a_peak_reserved: assert property (s_rd(8'h60) |=> {prdata[31:29], prdata[15:13]} == 6'h00)
        else $error("peak reserved bits set");
    a_debug_reserved: assert property (s_rd(8'h64) |=> {prdata[31:30], prdata[27:23]} == 7'h00)
        else $error("debug reserved bits set");
    a_period_write: assert property (wr_sel |=> velocity_period_sel == $past(pwdata[29:28]))
        else $error("period select not written");
    a_period_hold: assert property (!wr_sel |=> $stable(velocity_period_sel))
        else $error("period select moved");
    a_sar_route: assert property (s_rd(8'h64) ##1 prdata[22:16] == 7'h3b
        |-> prdata[11:0] == $past(debug_src.sar_adc)) else $error("adc not routed");
endmodule // rdc_observe_sva

bind rdc_observe rdc_observe_sva chk
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .angle_value, .angle_error_lock, .excitation_peak_trig, .sine_monitor_input,
    .cosine_monitor_input, .debug_src, .velocity_period_sel
);

// ===== tb/resolver_front_model.sv
// Far-side model: rotor angle ramp and the excitation peak trigger pin.
// Assumes the bench sets the angle step and asks for trigger pulses.
module resolver_front_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] rate,
    input  wire logic        fire,
    output logic      [15:0] angle,
    output logic             trig
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] trig_cnt_q;
    // Angle steps each cycle and wraps like a turning rotor
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            angle <= 16'h0000;
        else
            angle <= angle + rate;
    // Trigger held for 8 cycles so the pin filter surely sees it
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            trig_cnt_q <= 4'h0;
        else if (fire)
            trig_cnt_q <= 4'h8;
        else if (trig_cnt_q != 4'h0)
            trig_cnt_q <= trig_cnt_q - 4'h1;
    assign trig = (trig_cnt_q != 4'h0);
endmodule // resolver_front_model

// ===== tb/tb_rdc_observe.sv
// Testbench for rdc_observe: register reads, debug routing, velocity, lock, peaks.
// Assumes the front-end model drives angle and trigger; pready stays high.
module tb_rdc_observe;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [6:0] code; logic [15:0] data;} row_t;
    typedef struct packed {logic [1:0] per; logic [15:0] rate;} vrow_t;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [3:0]         pstrb = 4'h0;
    logic [3:0]         strb = 4'hf;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               lock = 1'b0;
    logic               fire = 1'b0;
    logic [15:0]        rate = 16'h0003;
    logic [12:0]        sin_mon = 13'h0000;
    logic [12:0]        cos_mon = 13'h0000;
    logic [15:0]        angle;
    logic               trig;
    logic [1:0]         per_sel;
    logic [31:0]        rd;
    logic               err_seen;
    logic [15:0]        delta;
    logic signed [24:0] v;
    int                 w;
    int                 error_cnt = 0;
    int                 n_tests = 0;
    int                 cyc = 0;
    rdc_obs_pkg::debug_src_t src = '{12'habc, 8'h5a, 16'h1234, 16'h8765, 10'h0a5,
                                     10'h15a, 13'h0555, 13'h0aaa};
    row_t  rows [9] = '{'{7'h3b, 16'h0abc}, '{7'h2f, 16'h005a}, '{7'h2e, 16'h1234},
                        '{7'h2d, 16'h8765}, '{7'h1d, 16'h00a5}, '{7'h1c, 16'h015a},
                        '{7'h1a, 16'h0555}, '{7'h19, 16'h0aaa}, '{7'h00, 16'h0000}};
    vrow_t vrows [4] = '{'{2'b00, 16'h0003}, '{2'b01, 16'hffff}, '{2'b10, 16'hfffe},
                         '{2'b11, 16'h0007}};
    // ----
    // Design, far side and clock
    // ----
    rdc_observe uut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .angle_value(angle), .angle_error_lock(lock), .excitation_peak_trig(trig),
        .sine_monitor_input(sin_mon), .cosine_monitor_input(cos_mon), .debug_src(src),
        .velocity_period_sel(per_sel)
    );
    resolver_front_model front
    (
        .pclk, .presetn, .rate, .fire, .angle, .trig
    );
    always #25 pclk = ~pclk;
    // Hang guard: whole run needs about 30000 cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            final_report();
        end
    end
    // ----
    // Tasks
    // ----
    // One APB transfer, entered just after a rising edge; request held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h5c, 32'h0);
        check("velocity reset", 32'h0, rd);
        apb(1'b0, 8'h60, 32'h0);
        check("peak reset", 32'h0, rd);
        apb(1'b0, 8'h64, 32'h0);
        check("debug reset", 32'h0, rd);
        $display("test reset done");
        // Every listed selector code, then an unlisted one; reserved bits written 0
        foreach (rows[i])
        begin
            apb(1'b1, 8'h64, {9'h000, rows[i].code, 16'h0000});
            apb(1'b0, 8'h64, 32'h0);
            check("debug port", {9'h000, rows[i].code, rows[i].data}, rd);
        end
        $display("test debug select done");
        // Two full windows at a steady rate give an exact expected value
        foreach (vrows[i])
        begin
            rate <= vrows[i].rate;
            apb(1'b1, 8'h64, {2'b00, vrows[i].per, 28'h0000000});
            w = (vrows[i].per == 2'b00) ? 256 : 512 << vrows[i].per;
            repeat (2 * w + 4) @(posedge pclk);
            delta = 16'(vrows[i].rate * w);
            v = {delta, 9'h000};
            apb(1'b0, 8'h5c, 32'h0);
            check("velocity", 32'(v), rd);
            check("period pin", {30'h0, vrows[i].per}, {30'h0, per_sel});
        end
        $display("test velocity done");
        apb(1'b1, 8'h5c, 32'hffffffff);
        repeat (1000) @(posedge pclk);
        apb(1'b0, 8'h5c, 32'h0);
        check("velocity after write", 32'(v), rd);
        lock <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, 8'h5c, 32'h0);
        check("velocity locked", 32'h0, rd);
        repeat (4100) @(posedge pclk);
        apb(1'b0, 8'h5c, 32'h0);
        check("velocity still locked", 32'h0, rd);
        lock <= 1'b0;
        repeat (8200) @(posedge pclk);
        apb(1'b0, 8'h5c, 32'h0);
        check("velocity after lock", 32'(v), rd);
        $display("test lock done");
        sin_mon <= 13'h1abc;
        cos_mon <= 13'h0123;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (16) @(posedge pclk);
        sin_mon <= 13'h0001;
        apb(1'b1, 8'h60, 32'hffffffff);
        apb(1'b0, 8'h60, 32'h0);
        check("peak samples", {3'b000, 13'h1abc, 3'b000, 13'h0123}, rd);
        $display("test peak capture done");
        apb(1'b0, 8'h68, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err_seen});
        check("unmapped data", 32'h0, rd);
        $display("test unmapped done");
        // Mid-run reset: period, selector and samples go back to reset values
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h64, 32'h0);
        check("debug after reset", 32'h0, rd);
        apb(1'b0, 8'h60, 32'h0);
        check("peak after reset", 32'h0, rd);
        apb(1'b0, 8'h5c, 32'h0);
        check("velocity after reset", 32'h0, rd);
        $display("test mid-run reset done");
        // Single-lane writes: each strobe reaches only its own field
        strb = 4'h4;
        apb(1'b1, 8'h64, {2'b00, 2'b11, 5'h00, 7'h3b, 16'h0000});
        strb = 4'hf;
        apb(1'b0, 8'h64, 32'h0);
        check("lane 2 write", {9'h000, 7'h3b, 16'h0abc}, rd);
        strb = 4'h8;
        apb(1'b1, 8'h64, {2'b00, 2'b01, 5'h00, 7'h00, 16'h0000});
        strb = 4'hf;
        apb(1'b0, 8'h64, 32'h0);
        check("lane 3 write", {2'b00, 2'b01, 5'h00, 7'h3b, 16'h0abc}, rd);
        check("lane 3 pin", 32'h1, {30'h0, per_sel});
        $display("test byte lanes done");
        final_report();
    end
endmodule // tb_rdc_observe
